// file: include/flash_prot_pkg.sv
/*
 Package for the flash write protection logic: command codes, register
 field positions, reset values, OTP geometry and protection range sizes.
 Assumes a command decoder outside that delivers decoded command pulses.
*/
package flash_prot_pkg;
	// ************************************************************
	// OTP geometry
	// ************************************************************
	localparam int OTP_BYTES       = 1024;
	localparam int OTP_REGIONS     = 32;
	localparam int OTP_REGION_SIZE = 32;
	localparam int OTP_ECC_CHUNK   = 16;
	localparam int OTP_CHUNKS      = OTP_BYTES / OTP_ECC_CHUNK;
	localparam logic [23:0] OTP_LOCK_BASE = 24'h000010;
	localparam int OTP_ADDR_W      = 10;

	// ************************************************************
	// Register field positions and reset values
	// ************************************************************
	localparam int FREEZE_POS      = 0;
	localparam int ORIGIN_POS      = 5;
	localparam int STATUS_LOCK_POS = 7;
	localparam int RANGE_LO_POS    = 2;
	localparam int PROG_ERR_POS    = 6;
	localparam int LATCH_POS       = 1;
	localparam logic [7:0] STATUS_NV_RESET = 8'h00;
	localparam logic [7:0] CONFIG_NV_RESET = 8'h00;

	// ************************************************************
	// Main array geometry: sizes in KB, address width in bits
	// ************************************************************
	localparam int ARRAY_KB      = 8192;
	localparam int ARRAY_ADDR_W  = 23;
	localparam int SMALLEST_KB   = 128;

	// ************************************************************
	// Command encoding seen on the command port
	// ************************************************************
	typedef enum logic [3:0] {
		cmd_none,
		cmd_write_latch_set,
		cmd_write_latch_clear,
		cmd_page_program,
		cmd_erase,
		cmd_register_write,
		cmd_otp_program,
		cmd_otp_read,
		cmd_protection_program
	} cmd_t;
endpackage : flash_prot_pkg

// file: core/range_decoder.sv
/*
 Block-protection range decoder: maps the three range select bits and the
 origin select to a protected address window, and ORs in sector protection.
 Assumes stable register inputs on the same clock as the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module range_decoder #(
	parameter int ADDR_W = flash_prot_pkg::ARRAY_ADDR_W
) (
	input  wire logic [2:0]        range_select,
	input  wire logic              range_origin_select,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              sector_protected,
	output logic                   protected_hit
);
	logic [ADDR_W:0] span;
	logic            block_hit;

	// Code 1 covers 1/64; each higher code doubles, code 7 covers all
	always_comb begin
		if (range_select == 3'h0)
			span = '0;
		else
			span = (ADDR_W+1)'(1) << (ADDR_W - 7 + 32'(range_select));
	end

	always_comb begin
		if (range_select == 3'h0)
			block_hit = 1'b0;
		else if (range_origin_select)
			block_hit = ({1'b0, addr} < span);
		else
			block_hit = ({1'b0, addr} >= ((ADDR_W+1)'(1) << ADDR_W) - span);
	end

	assign protected_hit = block_hit | sector_protected;
endmodule : range_decoder
`default_nettype wire

// file: core/flash_write_protect.sv
/*
 Write protection logic of a serial flash: write latch, OTP lock bytes
 and ECC tracking, freeze bit, write-protect pin interlock and gating of
 main array program/erase by protected range.
 Assumes a command decoder on sys_clk delivering one-cycle command pulses
 with address and data, and an array engine reporting completion.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_write_protect (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  cmd,
	input  wire logic [23:0] cmd_addr,
	input  wire logic [7:0]  cmd_data,
	input  wire logic        cmd_done,
	input  wire logic        write_protect_n_pin,
	input  wire logic        sector_protected,
	input  wire logic [7:0]  otp_array_rdata,
	output logic             write_latch_bit,
	output logic             prog_error,
	output logic [7:0]       status_reg1_volatile,
	output logic [7:0]       status_reg1_nonvolatile,
	output logic [7:0]       config_reg1_volatile,
	output logic [7:0]       config_reg1_nonvolatile,
	output logic             array_write_en,
	output logic             otp_write_en,
	output logic [9:0]       otp_write_addr,
	output logic [7:0]       otp_write_data,
	output logic             otp_ecc_en,
	output logic [7:0]       otp_read_data,
	output logic             otp_read_valid
);
	// ************************************************************
	// Pin synchroniser
	// ************************************************************
	logic wp_meta;
	logic wp_sync;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wp_meta <= 1'b1;
			wp_sync <= 1'b1;
		end else begin
			wp_meta <= write_protect_n_pin;
			wp_sync <= wp_meta;
		end
	end

	// ************************************************************
	// Command qualification
	// ************************************************************
	flash_prot_pkg::cmd_t op;
	assign op = flash_prot_pkg::cmd_t'(cmd);

	logic       freeze;
	logic       otp_in_range;
	logic [4:0] region;
	logic       region_locked;
	logic       lock_area;
	logic       otp_allowed;
	logic       regs_locked;
	logic       prot_hit;
	logic [31:0] lock_bits;
	logic [flash_prot_pkg::OTP_CHUNKS-1:0] chunk_used;
	logic [5:0] chunk;

	assign freeze = config_reg1_volatile[flash_prot_pkg::FREEZE_POS];
	assign otp_in_range = (cmd_addr < 24'(flash_prot_pkg::OTP_BYTES));
	assign region = cmd_addr[9:5];
	assign chunk = cmd_addr[9:4];
	// Upper half of region 0 holds the lock bytes
	assign lock_area = (cmd_addr[9:4] == 6'h01);
	assign region_locked = lock_area ? lock_bits[0] : lock_bits[region];
	assign otp_allowed = write_latch_bit && otp_in_range && !freeze && !region_locked;
	assign regs_locked = !wp_sync && status_reg1_nonvolatile[flash_prot_pkg::STATUS_LOCK_POS];

	range_decoder #(
		.ADDR_W(flash_prot_pkg::ARRAY_ADDR_W)
	) u_range (
		.range_select       (status_reg1_volatile[flash_prot_pkg::RANGE_LO_POS +: 3]),
		.range_origin_select(config_reg1_volatile[flash_prot_pkg::ORIGIN_POS]),
		.addr               (cmd_addr[flash_prot_pkg::ARRAY_ADDR_W-1:0]),
		.sector_protected   (sector_protected),
		.protected_hit      (prot_hit)
	);

	// ************************************************************
	// Write latch
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			write_latch_bit <= 1'b0;
		end else if (op == flash_prot_pkg::cmd_write_latch_set) begin
			write_latch_bit <= 1'b1;
		end else if (op == flash_prot_pkg::cmd_write_latch_clear || cmd_done) begin
			write_latch_bit <= 1'b0;
		end
	end

	// ************************************************************
	// Array write gating
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			array_write_en <= 1'b0;
		end else begin
			array_write_en <= write_latch_bit && !prot_hit &&
				(op == flash_prot_pkg::cmd_page_program ||
				 op == flash_prot_pkg::cmd_erase);
		end
	end

	// ************************************************************
	// OTP program, lock bytes and ECC tracking
	// ************************************************************
	// No erase command exists for OTP; lock and ECC state only ever set
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			otp_write_en   <= 1'b0;
			otp_write_addr <= '0;
			otp_write_data <= '0;
			otp_ecc_en     <= 1'b0;
		end else begin
			otp_write_en <= (op == flash_prot_pkg::cmd_otp_program) && otp_allowed;
			otp_write_addr <= cmd_addr[9:0];
			otp_write_data <= cmd_data;
			otp_ecc_en <= !chunk_used[chunk];
		end
	end

	// Lock bytes live in the array; mirror them as they are programmed
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lock_bits <= '0;
		end else if (op == flash_prot_pkg::cmd_otp_program && otp_allowed &&
				cmd_addr[9:2] == 8'h04) begin
			// Programming drives bits toward one-way locked state
			lock_bits[cmd_addr[1:0]*8 +: 8] <= lock_bits[cmd_addr[1:0]*8 +: 8] | cmd_data;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			chunk_used <= '0;
		end else if (op == flash_prot_pkg::cmd_otp_program && otp_allowed) begin
			// Any later program into this chunk runs without ECC
			chunk_used[chunk] <= 1'b1;
		end
	end

	// ************************************************************
	// Program error flag
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prog_error <= 1'b0;
		end else if (op == flash_prot_pkg::cmd_otp_program && otp_in_range &&
				write_latch_bit && (freeze || region_locked)) begin
			prog_error <= 1'b1;
		end else if (op == flash_prot_pkg::cmd_write_latch_clear) begin
			prog_error <= 1'b0;
		end
		// Out-of-range program leaves the flag alone
	end

	// ************************************************************
	// OTP read
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			otp_read_data  <= '0;
			otp_read_valid <= 1'b0;
		end else begin
			otp_read_valid <= (op == flash_prot_pkg::cmd_otp_read);
			// Out of range returns whatever the array port shows
			otp_read_data <= otp_array_rdata;
		end
	end

	// ************************************************************
	// Status and configuration registers
	// ************************************************************
	logic reg_write_ok;
	assign reg_write_ok = (op == flash_prot_pkg::cmd_register_write) && write_latch_bit &&
		!regs_locked;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			status_reg1_nonvolatile <= flash_prot_pkg::STATUS_NV_RESET;
			config_reg1_nonvolatile <= flash_prot_pkg::CONFIG_NV_RESET;
		end else if (reg_write_ok && cmd_addr[0] && !freeze) begin
			status_reg1_nonvolatile <= cmd_data;
			config_reg1_nonvolatile <= {cmd_addr[15:9], 1'b0};
		end
	end

	// Volatile copies load from the non-volatile ones on the first clock after reset
	logic loaded;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			loaded               <= 1'b0;
			status_reg1_volatile <= '0;
			config_reg1_volatile <= '0;
		end else if (!loaded) begin
			loaded               <= 1'b1;
			status_reg1_volatile <= status_reg1_nonvolatile;
			config_reg1_volatile <= config_reg1_nonvolatile;
		end else begin
			status_reg1_volatile[flash_prot_pkg::LATCH_POS]    <= write_latch_bit;
			status_reg1_volatile[flash_prot_pkg::PROG_ERR_POS] <= prog_error;
			if (reg_write_ok && !cmd_addr[0]) begin
				if (!freeze) begin
					// Range bits held while frozen
					status_reg1_volatile[flash_prot_pkg::RANGE_LO_POS +: 3] <=
						cmd_data[flash_prot_pkg::RANGE_LO_POS +: 3];
					config_reg1_volatile[7:1] <= cmd_addr[15:9];
				end
				// Freeze only ever sets until reset
				config_reg1_volatile[flash_prot_pkg::FREEZE_POS] <= freeze |
					cmd_addr[8];
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	property p_latch_set;
		@(posedge sys_clk) disable iff (rst)
		op == flash_prot_pkg::cmd_write_latch_set |=> write_latch_bit;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("latch not set");

	property p_latch_clear;
		@(posedge sys_clk) disable iff (rst)
		(op != flash_prot_pkg::cmd_write_latch_set) && cmd_done |=> !write_latch_bit;
	endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

	property p_freeze_err;
		@(posedge sys_clk) disable iff (rst)
		op == flash_prot_pkg::cmd_otp_program && otp_in_range && write_latch_bit && freeze
		|=> prog_error && !otp_write_en;
	endproperty
	a_freeze_err: assert property (p_freeze_err) else $error("frozen otp program");

	property p_out_range;
		@(posedge sys_clk) disable iff (rst)
		op == flash_prot_pkg::cmd_otp_program && !otp_in_range
		|=> !otp_write_en && prog_error == $past(prog_error);
	endproperty
	a_out_range: assert property (p_out_range) else $error("out of range otp");

	property p_locked_region;
		@(posedge sys_clk) disable iff (rst)
		op == flash_prot_pkg::cmd_otp_program && region_locked |=> !otp_write_en;
	endproperty
	a_locked_region: assert property (p_locked_region) else $error("locked region written");

	// Accepted OTP program; a second one four cycles on into the same chunk
	sequence s_otp_accept;
		op == flash_prot_pkg::cmd_otp_program && otp_allowed;
	endsequence

	property p_ecc_second;
		@(posedge sys_clk) disable iff (rst)
		s_otp_accept ##4 (op == flash_prot_pkg::cmd_otp_program && otp_allowed &&
			chunk == $past(chunk, 4)) |=> !otp_ecc_en;
	endproperty
	a_ecc_second: assert property (p_ecc_second) else $error("ecc kept on rewrite");

	property p_protected;
		@(posedge sys_clk) disable iff (rst)
		prot_hit |=> !array_write_en;
	endproperty
	a_protected: assert property (p_protected) else $error("protected array write");

	property p_wp_lock;
		@(posedge sys_clk) disable iff (rst)
		regs_locked && loaded |=> $stable(status_reg1_nonvolatile) &&
			$stable(config_reg1_volatile[7:1]);
	endproperty
	a_wp_lock: assert property (p_wp_lock) else $error("locked register changed");

	property p_freeze_hold;
		@(posedge sys_clk) disable iff (rst)
		freeze && loaded |=> freeze && $stable(status_reg1_volatile[4:2]);
	endproperty
	a_freeze_hold: assert property (p_freeze_hold) else $error("freeze not held");
endmodule : flash_write_protect
`default_nettype wire

// file: tb/flash_host_model.sv
/*
 Host side model: issues decoded command pulses and completion pulses,
 and holds the OTP array contents behind the protection logic.
 Assumes the protection block samples commands on the rising sys_clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
	input  wire logic        sys_clk,
	input  wire logic        otp_write_en,
	input  wire logic [9:0]  otp_write_addr,
	input  wire logic [7:0]  otp_write_data,
	output logic [3:0]       cmd,
	output logic [23:0]      cmd_addr,
	output logic [7:0]       cmd_data,
	output logic             cmd_done,
	output logic [7:0]       otp_array_rdata
);
	logic [7:0] mem [0:1023];

	initial begin
		cmd = 4'h0;
		cmd_addr = 24'h000000;
		cmd_data = 8'h00;
		cmd_done = 1'b0;
		for (int i = 0; i < 1024; i++) mem[i] = 8'hff;
	end

	// No erase path into the OTP store
	always @(posedge sys_clk) begin
		if (otp_write_en) mem[otp_write_addr] <= otp_write_data;
	end

	assign otp_array_rdata = mem[cmd_addr[9:0]];

	// Caller sends a latch set ahead of modifying commands, except the program-without-latch check in t_latch
	task issue(input logic [3:0] c, input logic [23:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#2;
		cmd = c;
		cmd_addr = a;
		cmd_data = d;
		@(posedge sys_clk);
		#2;
		cmd = 4'h0;
		// Stale address is not left on the bus
		cmd_addr = ~a;
		cmd_data = ~d;
	endtask : issue

	task done_pulse;
		@(posedge sys_clk);
		#2;
		cmd_done = 1'b1;
		@(posedge sys_clk);
		#2;
		cmd_done = 1'b0;
	endtask : done_pulse
endmodule : flash_host_model
`default_nettype wire

// file: tb/flash_write_protection_logic_tb.sv
/*
 Self-checking bench for the flash write protection logic.
 Assumes the host model drives commands and the OTP array read data.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; $display("wrong value at %0t: %s", $time, msg); end end
module flash_write_protection_logic_tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic write_protect_n_pin = 1'b1;
	logic sector_protected = 1'b0;
	logic [3:0] cmd;
	logic [23:0] cmd_addr;
	logic [7:0] cmd_data, otp_array_rdata, sr_v, sr_nv, cr_v, cr_nv, otp_write_data, otp_read_data;
	logic cmd_done, write_latch_bit, prog_error, array_write_en, otp_write_en, otp_ecc_en, otp_read_valid;
	logic [9:0] otp_write_addr;
	int error_cnt = 0;
	int n_tests = 0;

	always #12.5 sys_clk = ~sys_clk;

	flash_host_model host_i (.sys_clk(sys_clk), .otp_write_en(otp_write_en),
		.otp_write_addr(otp_write_addr), .otp_write_data(otp_write_data), .cmd(cmd),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_done(cmd_done),
		.otp_array_rdata(otp_array_rdata));

	flash_write_protect flash_write_protect_i (.sys_clk(sys_clk), .rst(rst), .cmd(cmd),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_done(cmd_done),
		.write_protect_n_pin(write_protect_n_pin), .sector_protected(sector_protected),
		.otp_array_rdata(otp_array_rdata), .write_latch_bit(write_latch_bit),
		.prog_error(prog_error), .status_reg1_volatile(sr_v), .status_reg1_nonvolatile(sr_nv),
		.config_reg1_volatile(cr_v), .config_reg1_nonvolatile(cr_nv),
		.array_write_en(array_write_en), .otp_write_en(otp_write_en),
		.otp_write_addr(otp_write_addr), .otp_write_data(otp_write_data),
		.otp_ecc_en(otp_ecc_en), .otp_read_data(otp_read_data), .otp_read_valid(otp_read_valid));

	// ************************************************************
	// Helpers
	// ************************************************************
	task close_out;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out

	task do_reset;
		rst = 1'b1;
		repeat (8) @(posedge sys_clk);
		#2;
		rst = 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask : do_reset

	task op(input logic [3:0] c, input logic [23:0] a, input logic [7:0] d);
		host_i.issue(flash_prot_pkg::cmd_write_latch_set, 24'h000000, 8'h00);
		host_i.issue(c, a, d);
	endtask : op

	task rw(input logic nv, input logic [7:0] st, input logic [7:0] cfg, input logic frz);
		op(flash_prot_pkg::cmd_register_write, {8'h00, cfg[7:1], frz, 7'h00, nv}, st);
	endtask : rw

	task otp(input logic [23:0] a, input logic [7:0] d, input logic en, input logic err);
		op(flash_prot_pkg::cmd_otp_program, a, d);
		`CHK(otp_write_en, en, "otp write enable")
		`CHK(prog_error, err, "program error flag")
	endtask : otp

	task prog(input logic [23:0] a, input logic prot);
		op(flash_prot_pkg::cmd_page_program, a, 8'h00);
		`CHK(array_write_en, ~prot, "array write gate")
	endtask : prog

	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_latch;
		`CHK({write_latch_bit, prog_error}, 2'b00, "state after reset")
		host_i.issue(flash_prot_pkg::cmd_write_latch_set, 24'h000000, 8'h00);
		`CHK(write_latch_bit, 1'b1, "latch set")
		host_i.done_pulse;
		`CHK(write_latch_bit, 1'b0, "latch after completion")
		op(flash_prot_pkg::cmd_write_latch_clear, 24'h000000, 8'h00);
		`CHK(write_latch_bit, 1'b0, "latch after clear command")
		host_i.issue(flash_prot_pkg::cmd_page_program, 24'h000100, 8'h00);
		`CHK(array_write_en, 1'b0, "program without latch")
	endtask : t_latch

	task t_otp;
		otp(24'h000020, 8'h5a, 1'b1, 1'b0);
		`CHK({otp_write_addr, otp_write_data, otp_ecc_en}, {10'h020, 8'h5a, 1'b1}, "first")
		otp(24'h00002f, 8'ha5, 1'b1, 1'b0);
		`CHK(otp_ecc_en, 1'b0, "repeat program drops ecc")
		sector_protected = 1'b1;
		otp(24'h0003ff, 8'h3c, 1'b1, 1'b0);
		`CHK({otp_write_addr, otp_ecc_en}, {10'h3ff, 1'b1}, "last otp byte")
		sector_protected = 1'b0;
		otp(24'h000400, 8'h11, 1'b0, 1'b0);
		host_i.issue(flash_prot_pkg::cmd_otp_read, 24'h0003ff, 8'h00);
		`CHK({otp_read_valid, otp_read_data}, {1'b1, 8'h3c}, "otp read back")
	endtask : t_otp

	task t_lock;
		otp(24'h000010, 8'h02, 1'b1, 1'b0);
		otp(24'h000020, 8'h00, 1'b0, 1'b1);
		@(posedge sys_clk);
		#2;
		`CHK({sr_v[6], sr_v[1]}, 2'b11, "status mirrors error and latch")
		host_i.issue(flash_prot_pkg::cmd_write_latch_clear, 24'h000000, 8'h00);
		otp(24'h000040, 8'h77, 1'b1, 1'b0);
		otp(24'h000010, 8'h01, 1'b1, 1'b0);
		otp(24'h000018, 8'h00, 1'b0, 1'b1);
		host_i.issue(flash_prot_pkg::cmd_write_latch_clear, 24'h000000, 8'h00);
	endtask : t_lock

	task setprot(input logic [2:0] c, input logic o);
		rw(1'b0, {3'b000, c, 2'b00}, {2'b00, o, 5'h00}, 1'b0);
		rw(1'b1, {3'b000, c, 2'b00}, {2'b00, o, 5'h00}, 1'b0);
		`CHK(sr_v[4:2], c, "range bits")
		`CHK({sr_nv[4:2], cr_nv[5], cr_v[5]}, {c, o, o}, "range and origin")
	endtask : setprot

	task t_range;
		int sz;
		for (int o = 0; o < 2; o++) begin
			for (int c = 0; c < 8; c++) begin
				sz = (c == 0) ? 0 : (32'h20000 << (c - 1));
				setprot(3'(c), 1'(o));
				prog((o == 0) ? 24'h7fffff : 24'h000000, c != 0);
				// Boundary byte just beyond the protected window
				if (c != 0 && c != 7) prog((o == 0) ? 24'h7fffff - 24'(sz) : 24'(sz), 1'b0);
			end
		end
		setprot(3'b000, 1'b0);
		sector_protected = 1'b1;
		prog(24'h000100, 1'b1);
		op(flash_prot_pkg::cmd_erase, 24'h000100, 8'h00);
		`CHK(array_write_en, 1'b0, "protected erase")
		sector_protected = 1'b0;
		op(flash_prot_pkg::cmd_erase, 24'h000100, 8'h00);
		`CHK(array_write_en, 1'b1, "open erase")
	endtask : t_range

	task t_wp;
		rw(1'b1, 8'h80, 8'h00, 1'b0);
		`CHK(sr_nv[7], 1'b1, "status write lock")
		write_protect_n_pin = 1'b0;
		repeat (3) @(posedge sys_clk);
		rw(1'b0, 8'h0c, 8'h20, 1'b0);
		`CHK({sr_v[4:2], cr_v[5]}, 4'b0000, "locked registers")
		write_protect_n_pin = 1'b1;
		repeat (3) @(posedge sys_clk);
		rw(1'b0, 8'h0c, 8'h00, 1'b0);
		`CHK(sr_v[4:2], 3'b011, "unlocked registers")
		rw(1'b1, 8'h00, 8'h00, 1'b0);
		rw(1'b0, 8'h00, 8'h00, 1'b0);
	endtask : t_wp

	task t_freeze;
		rw(1'b0, 8'h00, 8'h00, 1'b1);
		`CHK(cr_v[0], 1'b1, "freeze set")
		rw(1'b0, 8'h1c, 8'h00, 1'b0);
		`CHK(sr_v[4:2], 3'b000, "frozen range bits")
		otp(24'h000100, 8'h00, 1'b0, 1'b1);
		do_reset;
		`CHK({cr_v[0], write_latch_bit, prog_error}, 3'b000, "state after reset")
	endtask : t_freeze

	initial begin
		do_reset;
		t_latch;
		t_otp;
		t_lock;
		t_range;
		t_wp;
		t_freeze;
		close_out;
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		close_out;
	end
endmodule : flash_write_protection_logic_tb
`default_nettype wire
